// ---- qsfc_pkg.sv ----
// Purpose: shared constants for the quad serial flash controller
// Assumes: 100 MHz module clock, no register bus
// Notes: lane modes, widths and timing counts live here
package qsfc_pkg;
  localparam int QSFC_CLK_MHZ = 100; // module clock rate
  localparam int QSFC_WLEN_W = 7; // word length minus one field width
  localparam int QSFC_WCNT_W = 12; // word count minus one field width
  localparam int QSFC_DIV_W = 8; // serial clock divider field width
  localparam int QSFC_DLY_W = 2; // chip select to data delay width
  localparam int QSFC_WORD_MAX = 128; // longest word in bits
  localparam int QSFC_ADDR_W = 24; // mapped window address width
  localparam int QSFC_BIT_W = 8; // bit counter width
  localparam int QSFC_CS_HOLD = 2; // serial periods after last falling edge
  localparam logic [7:0] QSFC_RD_CMD = 8'h03; // single lane read command
  localparam logic [7:0] QSFC_QRD_CMD = 8'h6B; // quad output read command
  localparam logic [7:0] QSFC_DRD_CMD = 8'h3B; // dual output read command
  localparam logic [1:0] QSFC_LANE_1 = 2'h0; // one read line
  localparam logic [1:0] QSFC_LANE_2 = 2'h1; // two read lines
  localparam logic [1:0] QSFC_LANE_4 = 2'h2; // four read lines
  localparam logic [1:0] QSFC_PIN_3 = 2'h0; // clock, select, one shared line
  localparam logic [1:0] QSFC_PIN_4 = 2'h1; // clock, select, out and in
  localparam logic [1:0] QSFC_PIN_6 = 2'h2; // clock, select, four lines
  typedef enum logic [2:0] {QSFC_IDLE, QSFC_LEAD, QSFC_CMD, QSFC_DATA, QSFC_TAIL}
    qsfc_state_e;
endpackage

// ---- qsfc_ctrl.sv ----
// Purpose: serial flash controller with software frames and a mapped read path
// Assumes: serial data inputs come from off chip and are synchronised here
// Notes: clock mode zero, read data taken at the falling serial edge
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01 - controller only, always drives clock and select
// RULE_02 - reads on one, two or four lines
// RULE_03 - mapped reads become serial reads automatically
// RULE_04 - word length one to 128 bits
// RULE_05 - frame holds one to 4096 words
// RULE_06 - three, four or six pin wiring
// RULE_07 - optional pulse per word or frame
// RULE_08 - zero to three cycle select-to-data delay
// RULE_09 - clock mode zero, clock idles low
// RULE_10 - read data sampled on falling edge
// RULE_11 - flash launches data on falling edge
// RULE_12 - select released two periods after last fall
// RULE_13 - select leads first fall by delay plus one
// RULE_14 - idle: select high, clock low
// RULE_15 - divided serial clock runs only during transfers
module qsfc_ctrl import qsfc_pkg::*; (
  input wire logic clock, // module clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [QSFC_DIV_W-1:0] clk_div, // half period in clocks minus one
  input wire logic [QSFC_DLY_W-1:0] cs_to_data_delay, // extra select lead periods
  input wire logic [1:0] lane_mode, // read line count
  input wire logic [1:0] pin_mode, // wiring configuration
  input wire logic [QSFC_WLEN_W-1:0] word_len_m1, // bits per word minus one
  input wire logic [QSFC_WCNT_W-1:0] word_cnt_m1, // words per frame minus one
  input wire logic word_irq_en, // pulse on each word
  input wire logic frame_irq_en, // pulse on frame end
  input wire logic frame_start, // start a software read frame
  input wire logic [QSFC_WORD_MAX-1:0] tx_word, // bits sent from frame start, shifted on across words without reload
  input wire logic map_req, // mapped window read request
  input wire logic [QSFC_ADDR_W-1:0] map_addr, // mapped read address
  output logic map_ack, // mapped read done, data valid
  output logic [31:0] map_rdata, // mapped read data
  output logic [QSFC_WORD_MAX-1:0] rx_word, // last received word
  output logic rx_valid, // one cycle, new rx_word
  output logic word_irq, // word done pulse
  output logic frame_irq, // frame done pulse
  output logic busy, // transfer in progress
  output logic sclk, // serial clock
  output logic cs_n, // chip select, active low
  output logic [3:0] d_out, // data line outputs
  output logic [3:0] d_oe_n, // data line enables, low drives
  input wire logic [3:0] d_in // data line inputs
);
  qsfc_state_e st_q, st_d; // transfer state
  logic [QSFC_DIV_W-1:0] div_q, div_d; // divider counter
  logic sclk_q, sclk_d; // serial clock level
  logic cs_n_q, cs_n_d; // chip select level
  logic [1:0] lead_q, lead_d; // remaining select lead periods
  logic ph_q, ph_d; // half period phase while select leads
  logic [QSFC_BIT_W-1:0] bit_q, bit_d; // bits left in word
  logic [QSFC_WCNT_W-1:0] wcnt_q, wcnt_d; // words left in frame
  logic [QSFC_WORD_MAX-1:0] sh_q, sh_d; // transmit shifter
  logic [QSFC_WORD_MAX-1:0] rx_q, rx_d; // receive shifter
  logic [QSFC_WORD_MAX-1:0] rxo_q, rxo_d; // captured word
  logic rxv_q, rxv_d, wi_q, wi_d, fi_q, fi_d; // event pulses
  logic map_q, map_d; // current frame is a mapped read
  logic ack_q, ack_d; // mapped answer pulse
  logic [31:0] mdat_q, mdat_d; // mapped answer data
  logic [1:0] lane_q, lane_d; // lanes used in data phase
  logic [3:0] dout_q, dout_d, doe_q, doe_d; // pin drive
  logic [3:0] din_s1, din_s2; // input synchroniser
  logic tick; // divider half period end
  logic [2:0] step; // bits per falling edge
  logic [QSFC_WORD_MAX-1:0] rx_shift; // receive shifter after a sample
  logic last_bit; // this fall ends the word

  // two flop synchroniser on the data lines
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      din_s1 <= 4'h0;
      din_s2 <= 4'h0;
    end else begin
      din_s1 <= d_in;
      din_s2 <= din_s1;
    end
  end

  assign tick = (div_q == '0); // RULE_15
  // lane count sets bits per sample
  always_comb begin
    case (lane_q)
      QSFC_LANE_2: step = 3'h2; // RULE_02
      QSFC_LANE_4: step = 3'h4; // RULE_02
      default: step = 3'h1;
    endcase
  end
  // falling edge sampling, in pin 3 mode the shared line is line 0
  always_comb begin
    rx_shift = rx_q;
    case (lane_q)
      QSFC_LANE_2: rx_shift = {rx_q[QSFC_WORD_MAX-3:0], din_s2[1:0]}; // RULE_10
      QSFC_LANE_4: rx_shift = {rx_q[QSFC_WORD_MAX-5:0], din_s2}; // RULE_10
      default: rx_shift = {rx_q[QSFC_WORD_MAX-2:0],
        (pin_mode == QSFC_PIN_3) ? din_s2[0] : din_s2[1]}; // RULE_06
    endcase
  end
  assign last_bit = (bit_q <= QSFC_BIT_W'(step));

  // next state of the whole transfer engine
  always_comb begin
    st_d = st_q;
    div_d = tick ? clk_div : div_q - 1'b1;
    sclk_d = sclk_q;
    cs_n_d = cs_n_q;
    lead_d = lead_q;
    ph_d = ph_q;
    bit_d = bit_q;
    wcnt_d = wcnt_q;
    sh_d = sh_q;
    rx_d = rx_q;
    rxo_d = rxo_q;
    rxv_d = 1'b0;
    wi_d = 1'b0;
    fi_d = 1'b0;
    map_d = map_q;
    ack_d = 1'b0;
    mdat_d = mdat_q;
    lane_d = lane_q;
    dout_d = dout_q;
    doe_d = doe_q;
    case (st_q)
      QSFC_IDLE: begin
        sclk_d = 1'b0; // RULE_14
        cs_n_d = 1'b1; // RULE_14
        doe_d = 4'hF;
        div_d = clk_div;
        if (map_req) begin // RULE_03
          st_d = QSFC_LEAD;
          cs_n_d = 1'b0; // RULE_01
          map_d = 1'b1;
          lane_d = lane_mode;
          sh_d = '0;
          case (lane_mode)
            QSFC_LANE_2: sh_d[QSFC_WORD_MAX-1 -: 32] = {QSFC_DRD_CMD, map_addr};
            QSFC_LANE_4: sh_d[QSFC_WORD_MAX-1 -: 32] = {QSFC_QRD_CMD, map_addr};
            default: sh_d[QSFC_WORD_MAX-1 -: 32] = {QSFC_RD_CMD, map_addr};
          endcase
          // first bit goes out with select, well ahead of the first rise
          dout_d = {3'h0, sh_d[QSFC_WORD_MAX-1]};
          doe_d = 4'hE; // line 0 drives
          sh_d = {sh_d[QSFC_WORD_MAX-2:0], 1'b0};
          ph_d = 1'b0;
          bit_d = 8'd32;
          wcnt_d = '0;
          lead_d = cs_to_data_delay; // RULE_13
        end else if (frame_start) begin
          st_d = QSFC_LEAD;
          cs_n_d = 1'b0; // RULE_01
          map_d = 1'b0;
          lane_d = QSFC_LANE_1;
          // first bit goes out with select, well ahead of the first rise
          dout_d = {3'h0, tx_word[QSFC_WORD_MAX-1]};
          doe_d = 4'hE; // line 0 drives
          sh_d = {tx_word[QSFC_WORD_MAX-2:0], 1'b0};
          ph_d = 1'b0;
          bit_d = QSFC_BIT_W'(word_len_m1) + 1'b1; // RULE_04
          wcnt_d = word_cnt_m1; // RULE_05
          lead_d = cs_to_data_delay; // RULE_08
        end
      end
      QSFC_LEAD: begin
        // clock stays low: no stray edges reach the flash while select leads
        // first rise after 2*delay+1 half periods, so first fall is delay+1 periods in
        if (tick) begin
          if (!ph_q && lead_q == 2'h0) begin // RULE_13
            st_d = map_q ? QSFC_CMD : QSFC_DATA;
            sclk_d = 1'b1; // first rising edge, first bit already stable
          end else if (!ph_q) begin
            ph_d = 1'b1; // RULE_08
          end else begin
            ph_d = 1'b0;
            lead_d = lead_q - 2'h1; // RULE_08
          end
        end
      end
      QSFC_CMD: begin
        // mapped command and address, single line
        if (tick) begin
          sclk_d = ~sclk_q; // RULE_09
          if (sclk_q) begin
            bit_d = bit_q - 1'b1;
            if (bit_q == 8'd1) begin
              st_d = QSFC_DATA;
              // three pin wiring shares line 0, so it is released for the read
              doe_d = (lane_q == QSFC_LANE_1 && pin_mode != QSFC_PIN_3) ? 4'hE : 4'hF; // RULE_06
              bit_d = 8'd32;
              rx_d = '0;
            end else begin
              dout_d = {3'h0, sh_q[QSFC_WORD_MAX-1]};
              sh_d = {sh_q[QSFC_WORD_MAX-2:0], 1'b0};
            end
          end
        end
      end
      QSFC_DATA: begin
        if (tick) begin
          sclk_d = ~sclk_q; // RULE_09
          if (sclk_q) begin
            rx_d = rx_shift; // RULE_10
            dout_d = {3'h0, sh_q[QSFC_WORD_MAX-1]};
            sh_d = {sh_q[QSFC_WORD_MAX-2:0], 1'b0};
            bit_d = bit_q - QSFC_BIT_W'(step);
            if (last_bit) begin
              rxo_d = rx_shift;
              rxv_d = 1'b1;
              wi_d = word_irq_en; // RULE_07
              bit_d = map_q ? 8'd32 : QSFC_BIT_W'(word_len_m1) + 1'b1;
              rx_d = '0;
              if (wcnt_q == '0) begin // RULE_05
                st_d = QSFC_TAIL;
                fi_d = frame_irq_en; // RULE_07
                ack_d = map_q;
                mdat_d = rx_shift[31:0];
                lead_d = 2'(2 * QSFC_CS_HOLD - 1); // hold counted in half periods
                doe_d = 4'hF;
              end else begin
                wcnt_d = wcnt_q - 1'b1;
              end
            end
          end
        end
      end
      QSFC_TAIL: begin
        // clock stays low, select held two periods after last fall
        sclk_d = 1'b0;
        if (tick && sclk_q == 1'b0) begin
          if (lead_q == 2'h0) begin
            st_d = QSFC_IDLE;
            cs_n_d = 1'b1; // RULE_12
          end else begin
            lead_d = lead_q - 2'h1; // RULE_12
          end
        end
      end
      default: st_d = QSFC_IDLE;
    endcase
  end

  // registers of the transfer engine
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= QSFC_IDLE;
      div_q <= '0;
      sclk_q <= 1'b0; // RULE_14
      cs_n_q <= 1'b1; // RULE_14
      lead_q <= 2'h0;
      ph_q <= 1'b0;
      bit_q <= '0;
      wcnt_q <= '0;
      sh_q <= '0;
      rx_q <= '0;
      rxo_q <= '0;
      rxv_q <= 1'b0;
      wi_q <= 1'b0;
      fi_q <= 1'b0;
      map_q <= 1'b0;
      ack_q <= 1'b0;
      mdat_q <= 32'h0;
      lane_q <= QSFC_LANE_1;
      dout_q <= 4'h0;
      doe_q <= 4'hF;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      sclk_q <= sclk_d;
      cs_n_q <= cs_n_d;
      lead_q <= lead_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      wcnt_q <= wcnt_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      rxo_q <= rxo_d;
      rxv_q <= rxv_d;
      wi_q <= wi_d;
      fi_q <= fi_d;
      map_q <= map_d;
      ack_q <= ack_d;
      mdat_q <= mdat_d;
      lane_q <= lane_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
    end
  end

  // busy as a registered level
  logic busy_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (st_d != QSFC_IDLE);
    end
  end

  assign sclk = sclk_q;
  assign cs_n = cs_n_q;
  assign d_out = dout_q;
  assign d_oe_n = doe_q;
  assign rx_word = rxo_q;
  assign rx_valid = rxv_q;
  assign word_irq = wi_q;
  assign frame_irq = fi_q;
  assign map_ack = ack_q;
  assign map_rdata = mdat_q;
  assign busy = busy_q;
endmodule

// ---- qsfc_props.sv ----
// Purpose: timing checks at the controller ports
// Assumes: one clock domain, reset low
// Notes: select lead and tail counted in helper logic
`timescale 1ns/10ps
module qsfc_props import qsfc_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [QSFC_DIV_W-1:0] clk_div,
  input wire logic [QSFC_DLY_W-1:0] cs_to_data_delay,
  input wire logic map_req,
  input wire logic map_ack,
  input wire logic word_irq_en,
  input wire logic frame_irq_en,
  input wire logic word_irq,
  input wire logic frame_irq,
  input wire logic busy,
  input wire logic sclk,
  input wire logic cs_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [15:0] lead_q, gap_q, per, lead_x; // clock counts
  logic seen_q; // a serial fall seen in this frame
  assign per = 16'(clk_div) * 16'h2 + 16'h2;
  assign lead_x = per * (16'(cs_to_data_delay) + 16'h1);
  // clocks since select fell and since last serial fall
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lead_q <= 16'h0;
      gap_q <= 16'h0;
      seen_q <= 1'b0;
    end else if (cs_n) begin
      lead_q <= 16'h0;
      gap_q <= 16'h0;
      seen_q <= 1'b0;
    end else begin
      lead_q <= lead_q + 16'h1;
      gap_q <= $fell(sclk) ? 16'h0 : gap_q + 16'h1;
      seen_q <= seen_q | $fell(sclk);
    end
  end
  sequence s_take;
    !busy && cs_n && map_req;
  endsequence
  AST_LEAD: assert property ($fell(sclk) && !seen_q && !cs_n |->
    lead_q + 16'h2 >= lead_x && lead_q <= lead_x + 16'h2) else $error("select lead off");
  AST_TAIL: assert property ($rose(cs_n) |->
    gap_q + 16'h2 >= 2 * per && gap_q <= 2 * per + 16'h2) else $error("select tail off");
  AST_IDLE_LOW: assert property (cs_n |-> !sclk) else $error("clock runs idle");
  AST_CLK_BUSY: assert property (!busy |-> !sclk) else $error("clock not busy");
  AST_TAKE: assert property (s_take |=> !cs_n && busy) else $error("read not started");
  AST_ACK: assert property (map_ack |=> !map_ack) else $error("ack too long");
  AST_WIRQ: assert property (word_irq |-> word_irq_en) else $error("word pulse off");
  AST_FIRQ: assert property (frame_irq |-> frame_irq_en) else $error("frame pulse");
  AST_CS_BUSY: assert property (!cs_n |-> busy) else $error("select not busy");
  AST_MODE0: assert property ($fell(cs_n) |-> !sclk) else $error("select fell, clock high");
endmodule
bind qsfc_ctrl qsfc_props i_props (.clock, .rst_n, .clk_div, .cs_to_data_delay, .map_req,
  .map_ack, .word_irq_en, .frame_irq_en, .word_irq, .frame_irq, .busy, .sclk, .cs_n);

// ---- qsfc_flash_model.sv ----
// Purpose: behavioural serial flash for reads
// Assumes: command and address on d0, MSB first
// Notes: returns one fixed word after the address
`timescale 1ns/10ps
module qsfc_flash_model import qsfc_pkg::*; #(
  parameter logic [31:0] PAT = 32'hC3A55A3C // returned word
) (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic d0,
  output logic [3:0] dat,
  output logic [7:0] cmd,
  output logic [23:0] addr
);
  logic [31:0] sh = '0; // command shifter
  logic [31:0] rd = '0; // outgoing word
  int n = 0; // bits taken this frame
  initial dat = 4'h5;
  // new frame restarts the command phase
  always @(negedge cs_n) begin
    n = 0;
    rd = PAT;
  end
  // command and address taken on rising edges
  always @(posedge sclk) if (!cs_n && n < 32) begin
    sh = {sh[30:0], d0};
    n++;
    {cmd, addr} = sh;
  end
  // data launched on falling edges
  always @(negedge sclk) if (!cs_n && n == 32) begin
    case (cmd)
      QSFC_QRD_CMD: begin dat = rd[31:28]; rd = rd << 4; end
      QSFC_DRD_CMD: begin dat = {2{rd[31:30]}}; rd = rd << 2; end
      default: begin dat = {4{rd[31]}}; rd = rd << 1; end
    endcase
  end
  // released lines show the inverse of the last value
  always @(posedge cs_n) dat = ~dat;
endmodule

// ---- tb_top.sv ----
// Purpose: mapped reads and software frames
// Assumes: inputs driven on falling clock edge
// Notes: fixed read word from the flash model
`timescale 1ns/10ps
module tb_top import qsfc_pkg::*; ;
  localparam logic [31:0] PAT = 32'hC3A55A3C;
  logic clock = 0, rst_n = 0, map_req = 0, frame_start = 0;
  logic word_irq_en = 0, frame_irq_en = 0, map_ack, rx_valid, word_irq, frame_irq;
  logic busy, sclk, cs_n;
  logic [7:0] clk_div = 8'h03, cmd;
  logic [1:0] cs_to_data_delay = 0, lane_mode = 0, pin_mode = 2'h1;
  logic [6:0] word_len_m1 = 7'h0F;
  logic [11:0] word_cnt_m1 = 12'h003;
  logic [127:0] tx_word = '0, rx_word;
  logic [23:0] map_addr = '0, addr;
  logic [31:0] map_rdata;
  logic [3:0] d_out, d_oe_n, d_in, fl_d;
  int err_count = 0, check_count = 0, cyc = 0, n_w = 0, n_f = 0, n_r = 0;
  int lead_n = 0; // clocks from select low to first serial fall
  logic fell_seen = 1'b0, sclk_p = 1'b0;
  // each line carries whoever drives it
  assign d_in = (d_out & ~d_oe_n) | (fl_d & d_oe_n);
  qsfc_ctrl i_dut (.clock, .rst_n, .clk_div, .cs_to_data_delay, .lane_mode, .pin_mode,
    .word_len_m1, .word_cnt_m1, .word_irq_en, .frame_irq_en, .frame_start, .tx_word,
    .map_req, .map_addr, .map_ack, .map_rdata, .rx_word, .rx_valid, .word_irq, .frame_irq,
    .busy, .sclk, .cs_n, .d_out, .d_oe_n, .d_in);
  qsfc_flash_model #(.PAT(PAT)) i_flash (.sclk, .cs_n, .d0(d_in[0]), .dat(fl_d), .cmd, .addr);
  always #5 clock = ~clock;
  // pulse counters and hang guard
  always @(negedge clock) begin
    n_w += word_irq;
    n_f += frame_irq;
    n_r += rx_valid;
    // measure select lead up to the first serial fall
    if (cs_n) begin
      lead_n = 0;
      fell_seen = 1'b0;
    end else if (!fell_seen) begin
      lead_n++;
      fell_seen = sclk_p & ~sclk;
    end
    sclk_p = sclk;
    if (++cyc == 60000) begin
      err_count++;
      give_verdict;
    end
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_for(input bit ack);
    int n;
    n = 0;
    while ((ack ? map_ack !== 1'b1 : busy !== 1'b0) && n < 9000) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic map_read(input logic [1:0] ln, input logic [1:0] d);
    @(negedge clock);
    lane_mode = ln;
    pin_mode = (ln == QSFC_LANE_1) ? QSFC_PIN_3 : QSFC_PIN_6;
    cs_to_data_delay = d;
    clk_div = 8'h03 + 8'(d);
    map_addr = {8'hA0, 6'h0, ln, 6'h0, d};
    map_req = 1'b1;
    @(negedge clock);
    map_req = 1'b0;
    wait_for(1'b1);
    check(128'(map_rdata), 128'(PAT));
    check(128'(cmd), 128'(ln == 0 ? QSFC_RD_CMD : ln == 1 ? QSFC_DRD_CMD : QSFC_QRD_CMD));
    check(128'(addr), 128'(map_addr));
    check(128'(lead_n), 128'(2 * (4 + int'(d)) * (int'(d) + 1) + 1));
    wait_for(1'b0);
  endtask
  task automatic frame(input logic en);
    @(negedge clock);
    word_irq_en = en;
    frame_irq_en = en;
    pin_mode = QSFC_PIN_4;
    tx_word = {QSFC_RD_CMD, 24'h123456, 96'h0};
    n_w = 0;
    n_f = 0;
    n_r = 0;
    frame_start = 1'b1;
    @(negedge clock);
    frame_start = 1'b0;
    wait_for(1'b0);
    check(128'(n_w), en ? 128'h4 : 128'h0);
    check(128'(n_f), 128'(en));
    check(128'(n_r), 128'h4);
    check(128'(rx_word[15:0]), 128'(PAT[15:0]));
    check(128'(addr), 128'h123456);
  endtask
  initial begin
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    for (int l = 0; l < 3; l++) begin
      for (int d = 0; d < 4; d++) map_read(2'(l), 2'(d));
    end
    frame(1'b1);
    frame(1'b0);
    give_verdict;
  end
endmodule
